//--- include/split_addr_pkg.sv
// Package: constants and carriers for the split-address mux bus port
package split_addr_pkg;
  localparam int unsigned LOW_W          = 16;
  localparam int unsigned HIGH_W_DEF     = 11;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned CFG_SYNC_BIT   = 15;
  localparam int unsigned CFG_SPLIT_BIT  = 4;
  localparam logic [15:0] CFG_RESET      = 16'h8000;
  localparam logic        SYNC_SEL_VAL   = 1'h0;
  localparam logic        SPLIT_ON_VAL   = 1'h1;
  localparam int unsigned MAX_ADDR_PHASE = 2;
  // Sense time, ns, and cycles at 100 MHz (longest time rounds down)
  localparam int unsigned SENSE_NS       = 96;
  localparam int unsigned CLK_NS         = 10;
  localparam int unsigned SENSE_CYC      = (SENSE_NS / CLK_NS) < 1 ? 1 : SENSE_NS / CLK_NS;
  localparam int unsigned LATENCY_DEF    = 3;

  typedef struct packed {
    logic        cs_n;
    logic        oe_n;
    logic        we_n;
    logic        addr_valid_n;
    logic        clk;
  } bus_ctl_s;

  typedef enum logic [1:0] {
    SENSE_IDLE,
    SENSE_BUSY,
    SENSE_DONE
  } sense_e;
endpackage

//--- hdl/sync2.sv
// Two-flop synchroniser for a bus of levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_in,  // System clock
  input  wire logic         rst_n_in, // Synchronous reset, active low
  input  wire logic         ce_in,    // Clock enable
  input  wire logic [W-1:0] d_in,     // Asynchronous input
  input  wire logic [W-1:0] rst_val_in, // Constant reset value
  output logic      [W-1:0] q_out     // Synchronised output
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_r <= rst_val_in;
      q_out  <= rst_val_in;
    end else if (ce_in) begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- hdl/split_address_mux_bus_port.sv
// Split-address multiplexed bus port: address capture, sensing and wait
//
// Overview of operation
// - In asynchronous mode the wait output, when driven, shows valid data once sensing is done.
// - In synchronous mode wait shows valid data only once the latency has run and data is truly valid.
// - Asynchronous: an addr_valid_n rise with OE low latches the upper half in split mode only, with OE high the lower half.
// - Asynchronous reads start sensing when the lower half is latched.
// - Without an upper phase the retained upper address combines with the new lower address.
// - A synchronous single-phase cycle latches only the lower half and reuses the upper half.
// - Synchronous cycles latch on a rising link clock while addr_valid_n is low; sensing starts at the lower half.
// - addr_valid_n may stay low across both synchronous phases, captured on two consecutive clocks.
// - Split mode is enabled by config bit 4; reset gives plain mux mode; entry clears the upper address.
// - In split mode wait is driven exactly when the data lines are driven.
`timescale 1ns/100ps
`default_nettype none
module split_address_mux_bus_port
  import split_addr_pkg::*;
#(
  parameter int unsigned HIGH_W  = HIGH_W_DEF,
  parameter int unsigned LATENCY = LATENCY_DEF
) (
  input  wire logic                mclk_in,        // System clock, 100 MHz
  input  wire logic                rst_n_in,       // Synchronous reset, active low
  input  wire logic                ce_in,          // Clock enable, freezes state when low
  input  wire logic [15:0]         read_config_reg_in, // Read configuration register value
  input  wire bus_ctl_s            bus_ctl_in,     // Host control pins and link clock
  input  wire logic [LOW_W-1:0]    ad_in,          // Shared address/data bus, input side
  output logic      [DATA_W-1:0]   ad_out,         // Shared bus, output side
  output logic                     ad_oe_out,      // High while device drives the bus
  output logic                     wait_out,       // Wait pin, high means data valid
  output logic                     wait_oe_out,    // High while wait is driven
  input  wire logic [DATA_W-1:0]   array_data_in,  // Word from the array
  output logic [HIGH_W+LOW_W-1:0]  sense_addr_out, // Full word address to sense
  output logic                     sense_start_out, // One-cycle sense start pulse
  output logic                     write_addr_vld_out, // Latched address valid for a write
  output logic                     split_mode_out  // Split-address mode active
);
  localparam int unsigned CTL_W = $bits(bus_ctl_s);

  bus_ctl_s               ctl_s;
  logic [LOW_W-1:0]       ad_s;
  logic                   clk_d_r;
  logic                   adv_d_r;
  logic [HIGH_W-1:0]      upper_r;
  logic [LOW_W-1:0]       lower_r;
  logic                   split_r;
  logic [1:0]             phase_cnt_r;
  logic                   lower_hit;
  logic                   upper_hit;
  logic                   async_mode;
  logic                   clk_rise;
  logic                   adv_rise;
  logic                   cap_ok;
  sense_e                 sense_r;
  logic [7:0]             sense_cnt_r;
  logic [7:0]             lat_cnt_r;
  logic                   data_valid;
  logic                   split_req;
  logic                   drive_en;

  sync2 #(.W(CTL_W)) u_sync_ctl (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .d_in       (bus_ctl_in),
    .rst_val_in (CTL_W'(5'h1e)),
    .q_out      (ctl_s)
  );

  sync2 #(.W(LOW_W)) u_sync_ad (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .d_in       (ad_in),
    .rst_val_in ({LOW_W{1'b0}}),
    .q_out      (ad_s)
  );

  assign async_mode = read_config_reg_in[CFG_SYNC_BIT] != SYNC_SEL_VAL;
  assign clk_rise   = ctl_s.clk && !clk_d_r;
  assign adv_rise   = ctl_s.addr_valid_n && !adv_d_r;
  assign cap_ok     = !ctl_s.cs_n && phase_cnt_r < 2'(MAX_ADDR_PHASE);
  assign split_req  = read_config_reg_in[CFG_SPLIT_BIT] == SPLIT_ON_VAL;
  assign drive_en   = !ctl_s.cs_n && !ctl_s.oe_n && ctl_s.we_n && phase_cnt_r != 2'h0;

  // Capture moment: addr_valid_n rise (async) or clock rise with addr_valid_n low (sync)
  always_comb begin
    logic strobe;
    strobe = 1'b0;
    if (async_mode)
      strobe = adv_rise;
    else
      strobe = clk_rise && !ctl_s.addr_valid_n;
    upper_hit = strobe && cap_ok && split_r && !ctl_s.oe_n;
    lower_hit = strobe && cap_ok && ctl_s.oe_n;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      clk_d_r <= 1'b0;
      adv_d_r <= 1'b1;
    end else if (ce_in) begin
      clk_d_r <= ctl_s.clk;
      adv_d_r <= ctl_s.addr_valid_n;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      split_r <= 1'b0;
    end else if (ce_in) begin
      split_r <= split_req;
    end
  end

  // Phases counted per bus cycle; chip deselect ends the cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase_cnt_r <= 2'h0;
    end else if (ce_in) begin
      if (ctl_s.cs_n)
        phase_cnt_r <= 2'h0;
      else if (upper_hit || lower_hit)
        phase_cnt_r <= phase_cnt_r + 2'h1;
    end
  end

  // upper field above the word address
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      upper_r <= {HIGH_W{1'b0}};
    end else if (ce_in) begin
      if (!split_r && split_req)
        upper_r <= {HIGH_W{1'b0}};
      // upper then lower on consecutive clocks
      else if (upper_hit)
        upper_r <= ad_s[HIGH_W-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lower_r <= {LOW_W{1'b0}};
    end else if (ce_in && lower_hit) begin
      lower_r <= ad_s;
    end
  end

  assign sense_addr_out = {upper_r, lower_r};
  assign split_mode_out = split_r;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sense_start_out    <= 1'b0;
      write_addr_vld_out <= 1'b0;
    end else if (ce_in) begin
      sense_start_out    <= lower_hit && ctl_s.we_n;
      write_addr_vld_out <= lower_hit && !ctl_s.we_n;
    end
  end

  // Sense timer; a new lower latch for a read restarts it
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sense_r     <= SENSE_IDLE;
      sense_cnt_r <= 8'h0;
    end else if (ce_in) begin
      unique case (sense_r)
        SENSE_IDLE: begin
          if (sense_start_out) begin
            sense_r     <= SENSE_BUSY;
            sense_cnt_r <= 8'(SENSE_CYC);
          end
        end
        SENSE_BUSY: begin
          if (sense_start_out)
            sense_cnt_r <= 8'(SENSE_CYC);
          else if (sense_cnt_r <= 8'h1)
            sense_r <= SENSE_DONE;
          else
            sense_cnt_r <= sense_cnt_r - 8'h1;
        end
        SENSE_DONE: begin
          if (sense_start_out) begin
            sense_r     <= SENSE_BUSY;
            sense_cnt_r <= 8'(SENSE_CYC);
          end else if (ctl_s.cs_n) begin
            sense_r <= SENSE_IDLE;
          end
        end
      endcase
    end
  end

  // Latency count in link clocks after the lower latch
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      lat_cnt_r <= 8'h0;
    end else if (ce_in) begin
      if (lower_hit || ctl_s.cs_n)
        lat_cnt_r <= 8'h0;
      else if (clk_rise && lat_cnt_r < 8'(LATENCY))
        lat_cnt_r <= lat_cnt_r + 8'h1;
    end
  end

  always_comb begin
    if (async_mode)
      data_valid = sense_r == SENSE_DONE;
    else
      data_valid = sense_r == SENSE_DONE && lat_cnt_r >= 8'(LATENCY);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ad_out      <= {DATA_W{1'b0}};
      ad_oe_out   <= 1'b0;
      wait_out    <= 1'b0;
      wait_oe_out <= 1'b0;
    end else if (ce_in) begin
      ad_oe_out   <= drive_en;
      wait_oe_out <= drive_en;
      wait_out    <= data_valid;
      ad_out      <= data_valid ? array_data_in : ad_out;
    end
  end
endmodule
`default_nettype wire

//--- bench/split_port_asserts.sv
// Checker: port rules of the split-address bus port
`timescale 1ns/100ps
`default_nettype none
module split_port_asserts
  import split_addr_pkg::*;
#(parameter int unsigned LATENCY = LATENCY_DEF) (
  input wire logic        mclk_in,            // clk
  input wire logic        rst_n_in,           // rst
  input wire logic        ce_in,              // en
  input wire logic [15:0] read_config_reg_in, // cfg
  input wire bus_ctl_s    bus_ctl_in,         // pins
  input wire logic        ad_oe_out,          // drive
  input wire logic        wait_out,           // wait
  input wire logic        wait_oe_out,        // wait drive
  input wire logic        sense_start_out,    // sense
  input wire logic        write_addr_vld_out, // write
  input wire logic        split_mode_out      // split
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic [1:0] adv_r, lck_r;
  logic [3:0] pin_r;
  int         age_r, sen_r, lnk_r;
  wire        cap = adv_r == 2'h1 || (lck_r == 2'h1 && !adv_r[0]);
  always_ff @(posedge mclk_in) begin
    adv_r <= {adv_r[0], bus_ctl_in.addr_valid_n};
    lck_r <= {lck_r[0], bus_ctl_in.clk};
    pin_r <= {pin_r[2:0], bus_ctl_in.cs_n | bus_ctl_in.oe_n};
  end
  // Cycles since a capture edge, since sense start, link rises since start
  always_ff @(posedge mclk_in) begin
    age_r <= (!rst_n_in) ? 999 : cap ? 0 : age_r + 1;
  end
  always_ff @(posedge mclk_in) begin
    sen_r <= (!rst_n_in || sense_start_out) ? 0 : sen_r + 1;
  end
  always_ff @(posedge mclk_in) begin
    lnk_r <= (!rst_n_in || sense_start_out) ? 0 : lnk_r + int'(lck_r == 2'h1);
  end
  property p_wait_oe; wait_oe_out == ad_oe_out; endproperty
  a_wait_oe: assert property (p_wait_oe) else $error("wait drive");
  property p_oe_pin; ad_oe_out |-> !pin_r[2] || !pin_r[3]; endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("bus drive");
  property p_split; $past(rst_n_in) && $past(ce_in) |-> split_mode_out == $past(read_config_reg_in[4]); endproperty
  a_split: assert property (p_split) else $error("split mode");
  property p_cap; sense_start_out || write_addr_vld_out |-> age_r <= 8; endproperty
  a_cap: assert property (p_cap) else $error("latch cause");
  property p_pulse; sense_start_out |=> !sense_start_out && !write_addr_vld_out; endproperty
  a_pulse: assert property (p_pulse) else $error("sense pulse");
  property p_wpulse; write_addr_vld_out |-> !sense_start_out ##1 !write_addr_vld_out; endproperty
  a_wpulse: assert property (p_wpulse) else $error("write pulse");
  property p_sense; $rose(wait_out) |-> sen_r >= SENSE_CYC; endproperty
  a_sense: assert property (p_sense) else $error("early wait");
  property p_lat; $rose(wait_out) && !read_config_reg_in[15] |-> lnk_r >= LATENCY - 1; endproperty
  a_lat: assert property (p_lat) else $error("latency");
  c_read: cover property (sense_start_out);
  c_write: cover property (write_addr_vld_out);
  c_sync: cover property ($rose(wait_out) && !read_config_reg_in[15]);
endmodule
bind split_address_mux_bus_port split_port_asserts #(.LATENCY(LATENCY)) i_chk (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .ce_in(ce_in), .read_config_reg_in(read_config_reg_in), .bus_ctl_in(bus_ctl_in),
  .ad_oe_out(ad_oe_out), .wait_out(wait_out), .wait_oe_out(wait_oe_out), .sense_start_out(sense_start_out),
  .write_addr_vld_out(write_addr_vld_out), .split_mode_out(split_mode_out));
`default_nettype wire

//--- bench/host_model.sv
// Host controller model for the split-address bus
`timescale 1ns/100ps
`default_nettype none
module host_model
  import split_addr_pkg::*;
(
  input  wire logic        mclk_in, // clk
  output var bus_ctl_s     ctl_out, // pins
  output logic      [15:0] ad_out,  // bus
  output logic             rel_out  // released
);
  logic        run;
  logic [15:0] d;
  initial begin
    ctl_out = 5'h1e;
    run = 0;
    rel_out = 1;
    d = 16'h0;
  end
  // Link clock stands still outside sync frames
  // Offset keeps link edges clear of system clock edges
  initial begin
    #2;
    forever #62.5 ctl_out.clk = run ? ~ctl_out.clk : 1'b0;
  end
  assign ad_out = rel_out ? ~d : d;
  task automatic st(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic ph(bit sy, bit lw, logic [15:0] a);
    if (sy) @(negedge ctl_out.clk);
    ctl_out.oe_n = lw;
    d = a;
    rel_out = 0;
    ctl_out.addr_valid_n = 0;
    if (sy) begin
      @(posedge ctl_out.clk);
      #30;
    end else begin
      st(3);
      ctl_out.addr_valid_n = 1;
      st(3);
    end
  endtask
  task automatic adr(bit sy, bit two, bit wr, logic [15:0] up, logic [15:0] lo);
    run = sy;
    ctl_out.cs_n = 0;
    ctl_out.we_n = !wr;
    if (two) ph(sy, 0, up);
    ph(sy, 1, lo);
    ctl_out.addr_valid_n = 1;
  endtask
  task automatic dat();
    rel_out = 1;
    ctl_out.oe_n = 0;
  endtask
  // frame end: deselect, stop link clock, release bus, then six idle clocks
  task automatic fin();
    run = 0;
    ctl_out = 5'h1e;
    rel_out = 1;
    st(6);
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Testbench: reads and writes through the split-address port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import split_addr_pkg::*;
  logic                         mclk_in, rst_n_in, sp, rel, oe, wt, wt_oe, sst, wv, sm, wr_m, ce;
  logic [15:0]                  cfg, h_ad, dv_ad, arr, up, lo;
  logic [10:0]                  up_m;
  logic [HIGH_W_DEF+LOW_W-1:0]  sad, exp_a;
  bus_ctl_s                     ctl;
  int                           err_count, num_checks, nst, n;
  logic [4:0]                   tbl [11] = '{5'h04, 5'h08, 5'h0c, 5'h08, 5'h0e, 5'h09, 5'h08, 5'h1c, 5'h18,
    5'h1e, 5'h08};
  host_model i_host_model (.mclk_in(mclk_in), .ctl_out(ctl), .ad_out(h_ad), .rel_out(rel));
  split_address_mux_bus_port i_split_address_mux_bus_port (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .ce_in(ce), .read_config_reg_in(cfg), .bus_ctl_in(ctl), .ad_in(rel && oe ? dv_ad : h_ad),
    .ad_out(dv_ad), .ad_oe_out(oe), .wait_out(wt), .wait_oe_out(wt_oe), .array_data_in(arr),
    .sense_addr_out(sad), .sense_start_out(sst), .write_addr_vld_out(wv), .split_mode_out(sm));
  initial begin
    mclk_in = 0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic chk(bit c, string m);
    num_checks++;
    if (!c) begin
      err_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk_in) if (rst_n_in && (sst || wv)) begin
    nst++;
    chk(sad === exp_a && wv === wr_m, "address");
  end
  // Entry bits: sync, split, two phases, write, abort
  task automatic cyc(logic [4:0] t);
    cfg = {~t[4], CFG_RESET[14:5], t[3], CFG_RESET[3:0]};
    if (t[3] && !sp) up_m = 11'h0;
    sp = t[3];
    up = 16'($urandom);
    lo = 16'($urandom);
    arr = 16'($urandom);
    if (t[3] && t[2]) up_m = up[10:0];
    exp_a = {up_m, lo};
    wr_m = t[1];
    nst = 0;
    i_host_model.st(4);
    i_host_model.adr(t[4], t[2], t[1], up, lo);
    if (t[1:0] == 2'h0) begin
      i_host_model.dat();
      n = 0;
      while (wt !== 1'b1 && n < 100) begin
        i_host_model.st(1);
        n++;
      end
      chk(n < 100 && dv_ad === arr && wt_oe === 1'b1 && oe === 1'b1, "read data");
    end else begin
      i_host_model.st(4);
    end
    i_host_model.fin();
    chk(nst == 1 && oe === 1'b0 && wt_oe === 1'b0 && sm === t[3], "cycle end");
  endtask
  initial begin
    rst_n_in = 0;
    ce = 1;
    cfg = CFG_RESET;
    arr = 16'h0;
    sp = 0;
    up_m = 11'h0;
    err_count = 0;
    num_checks = 0;
    void'($urandom(15));
    repeat (8) @(posedge mclk_in);
    #1;
    rst_n_in = 1;
    i_host_model.st(3);
    chk(sm === 1'b0 && sst === 1'b0, "reset state");
    ce = 0;
    cfg[CFG_SPLIT_BIT] = 1'b1;
    i_host_model.st(4);
    chk(sm === 1'b0 && sst === 1'b0, "enable hold");
    cfg = CFG_RESET;
    ce = 1;
    foreach (tbl[i]) cyc(tbl[i]);
    end_of_test();
  end
  initial begin
    #300000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
